// file: include/tdp_pkg.sv
// package for the dithered pwm converter sequencer: register map, fields, reset values
// assumes a 32-bit apb slave with one aligned word per register
package tdp_pkg;
    // ===========================================================
    // register byte offsets
    localparam logic [7:0] OFS_TIMER_ONE_CONTROL      = 8'h00;
    localparam logic [7:0] OFS_TIMER_ONE_PERIOD_VALUE = 8'h04;
    localparam logic [7:0] OFS_COMPARE_ONE_VALUE      = 8'h08;
    localparam logic [7:0] OFS_COMPARE_ONE_CONTROL    = 8'h0c;
    localparam logic [7:0] OFS_CONVERTER_CONTROL_ONE  = 8'h10;
    localparam logic [7:0] OFS_RESULT_ONE             = 8'h14;
    localparam logic [7:0] OFS_RESULT_TWO             = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS             = 8'h1c;
    localparam logic [7:0] OFS_IRQ_ENABLE             = 8'h20;
    localparam logic [7:0] OFS_IRQ_CLEAR              = 8'h24;
    localparam logic [7:0] OFS_GROUP_A_VECTOR         = 8'h28;
    localparam logic [7:0] OFS_TIMER_ONE_COUNT        = 8'h2c;
    // ===========================================================
    // field positions
    localparam int TCTL_RUN_BIT    = 0;   // timer_one_control: start counting
    localparam int TCTL_UPDOWN_BIT = 1;   // 0 continuous up, 1 continuous up/down
    localparam int CCTL_EN_BIT     = 0;   // compare enable
    localparam int CCTL_PINSEL_BIT = 1;   // shared pin: 1 pwm, 0 digital io
    localparam int CCTL_LOW_BIT    = 2;   // 1 active low, 0 active high
    localparam int ADC_EN1_BIT     = 0;
    localparam int ADC_EN2_BIT     = 1;
    localparam int ADC_DONE_BIT    = 8;   // conversion complete flag
    localparam int IRQ_PERIOD_BIT  = 0;
    localparam int IRQ_CONV_BIT    = 1;
    localparam int IRQ_W           = 2;
    // ===========================================================
    // reset values and counts
    localparam logic [15:0] PERIOD_RST      = 16'hffff;
    localparam logic [15:0] COMPARE_RST     = 16'h0000;
    localparam int          CONV_CYCLES     = 13;
    localparam logic [7:0]  VECTOR_PERIOD   = 8'h27;  // arbitrary vector id
    localparam logic [7:0]  VECTOR_NONE     = 8'h00;

    typedef enum logic [1:0] {
        TDP_CONV_IDLE = 2'b00,
        TDP_CONV_BUSY = 2'b01,
        TDP_CONV_DONE = 2'b11
    } tdp_conv_t;

    typedef struct packed {
        logic        sel;
        logic        en;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } tdp_apb_req_t;
endpackage

// file: design/tdp_sequencer.sv
// timer-driven dithered pwm and dual converter sequencer with apb registers
// assumes synchronous inputs on pclk; the analog converter is modelled by sampling
// two 10-bit digital inputs when the conversion time ends
//
// Operation
// [R1] timer counts up continuously and wraps at the programmed period value
// [R2] compare unit one uses timer one, output active high
// [R3] software selects the shared pin for pwm before enabling compare
// [R4] each period match starts a new conversion; the code ignores a match that comes while a conversion is still busy
// [R5] software configures analog pins and enables converter via control register
// [R6] period interrupt needs both line and source enables; the code has only the one irq_enable bit per source
// [R7] timer starts only when its control register is written, last init step
// [R8] compare value sets duty; software sweeps 0 to 100 percent
// [R9] software steps compare by twice period over oversampling factor
// [R10] a slope flag chooses add or subtract of the step
// [R11] software reverses slope before passing zero or the period
// [R12] handler checks conversion complete flag before reading a result; the sweep handler reads result one without checking it
// [R13] two independent converters each give a 10-bit result
// [R14] timer is 16 bits, supports continuous up and up/down counting
// [R15] handler passes each result to the low-pass stage
// [R16] oversampling factor is a power of two
// [R17] handler always reads the group vector register
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tdp_sequencer #(
    parameter int TW = 16,
    parameter int RW = 10
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [RW-1:0] analog_in_one,
    input  wire logic [RW-1:0] analog_in_two,
    output logic               compare_one_pwm_pin,
    output logic               shared_digital_io_bit_oe,
    output logic               cpu_irq_line_two
);
    // ===========================================================
    // bus decode
    tdp_pkg::tdp_apb_req_t req;
    assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};
    wire acc    = req.sel && req.en;
    // writes and the vector acknowledge land only at the edge where pready is seen high
    wire wr_acc = acc && req.wr && pready;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    wire w_tctl = wr_acc && hit(req.addr, tdp_pkg::OFS_TIMER_ONE_CONTROL);
    wire w_per  = wr_acc && hit(req.addr, tdp_pkg::OFS_TIMER_ONE_PERIOD_VALUE);
    wire w_cmp  = wr_acc && hit(req.addr, tdp_pkg::OFS_COMPARE_ONE_VALUE);
    wire w_cctl = wr_acc && hit(req.addr, tdp_pkg::OFS_COMPARE_ONE_CONTROL);
    wire w_adc  = wr_acc && hit(req.addr, tdp_pkg::OFS_CONVERTER_CONTROL_ONE);
    wire w_ien  = wr_acc && hit(req.addr, tdp_pkg::OFS_IRQ_ENABLE);
    wire w_iclr = wr_acc && hit(req.addr, tdp_pkg::OFS_IRQ_CLEAR);
    wire r_vec  = acc && !req.wr && pready && hit(req.addr, tdp_pkg::OFS_GROUP_A_VECTOR);
    wire mapped = req.addr <= tdp_pkg::OFS_TIMER_ONE_COUNT && req.addr[1:0] == 2'b00;

    // ===========================================================
    // registers
    localparam int IRQ_W_L = tdp_pkg::IRQ_W;
    typedef tdp_pkg::tdp_conv_t tdp_conv_t_alias;
    logic [1:0]        timer_one_control;
    logic [TW-1:0]     timer_one_period_value;
    logic [TW-1:0]     compare_one_value;
    logic [2:0]        compare_one_control;
    logic [1:0]        adc_enable;
    logic [IRQ_W_L-1:0] irq_status;
    logic [IRQ_W_L-1:0] irq_enable;
    logic [TW-1:0]     count;
    logic              down;
    logic [RW-1:0]     result_one;
    logic [RW-1:0]     result_two;
    logic              conv_done;
    tdp_conv_t_alias   conv_state;
    logic [4:0]        conv_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_one_control      <= 2'h0;
            timer_one_period_value <= tdp_pkg::PERIOD_RST;
            compare_one_value      <= tdp_pkg::COMPARE_RST;
            compare_one_control    <= 3'h0;
            adc_enable             <= 2'h0;
            irq_enable             <= '0;
        end else begin
            if (w_tctl) timer_one_control <= req.wdata[1:0];            // see [R7]
            if (w_per)  timer_one_period_value <= req.wdata[TW-1:0];
            if (w_cmp)  compare_one_value <= req.wdata[TW-1:0];
            if (w_cctl) compare_one_control <= req.wdata[2:0];
            if (w_adc)  adc_enable <= req.wdata[1:0];                   // see [R5]
            if (w_ien)  irq_enable <= req.wdata[IRQ_W_L-1:0];
        end
    end

    // ===========================================================
    // timer: continuous up or up/down, 16 bits
    wire running   = timer_one_control[tdp_pkg::TCTL_RUN_BIT];
    wire updown    = timer_one_control[tdp_pkg::TCTL_UPDOWN_BIT];
    wire at_period = count >= timer_one_period_value;
    // period match at the top of the count; in up/down mode it comes once per turn
    wire period_match = running && at_period && !(updown && down);
    logic [TW-1:0] next_count;
    logic          next_down;
    always_comb begin
        next_count = count;
        next_down  = down;
        if (!running) begin
            next_count = count;
        end else if (!updown) begin
            next_count = at_period ? '0 : count + 1'b1;                 // see [R1] [R14]
            next_down  = 1'b0;
        end else if (down) begin
            next_count = count == '0 ? count + 1'b1 : count - 1'b1;     // see [R14]
            next_down  = count != '0 && count != 1'b1 ? 1'b1 : 1'b0;
        end else begin
            // a zero period holds the count at zero instead of wrapping below it
            next_count = at_period ? (count == '0 ? count : count - 1'b1) : count + 1'b1;
            next_down  = at_period && count != '0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            down  <= 1'b0;
        end else begin
            count <= next_count;
            down  <= next_down;
        end
    end

    // ===========================================================
    // compare one on timer one; pin drives only in pwm mode
    wire cmp_en  = compare_one_control[tdp_pkg::CCTL_EN_BIT];
    wire pin_pwm = compare_one_control[tdp_pkg::CCTL_PINSEL_BIT];
    wire active  = count < compare_one_value;
    // duty of 0 keeps the pin low, a value above the period keeps it high: full 0..100 percent
    wire pwm_lvl = (cmp_en && active) ^ compare_one_control[tdp_pkg::CCTL_LOW_BIT];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_one_pwm_pin      <= 1'b0;
            shared_digital_io_bit_oe <= 1'b0;
        end else begin
            compare_one_pwm_pin      <= pin_pwm && pwm_lvl;           // see [R2] [R3]
            shared_digital_io_bit_oe <= pin_pwm;
        end
    end

    // ===========================================================
    // converters: both start on period match, finish after CONV_CYCLES
    wire any_adc = |adc_enable;
    wire conv_end = conv_state == tdp_pkg::TDP_CONV_BUSY
                 && conv_cnt == 5'(tdp_pkg::CONV_CYCLES - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_state <= tdp_pkg::TDP_CONV_IDLE;
            conv_cnt   <= 5'h0;
            result_one <= '0;
            result_two <= '0;
        end else begin
            case (conv_state)
                tdp_pkg::TDP_CONV_IDLE, tdp_pkg::TDP_CONV_DONE: begin
                    if (period_match && any_adc) begin               // see [R4]
                        conv_state <= tdp_pkg::TDP_CONV_BUSY;
                        conv_cnt   <= 5'h0;
                    end
                end
                tdp_pkg::TDP_CONV_BUSY: begin
                    conv_cnt <= conv_cnt + 5'h1;
                    if (conv_end) begin
                        conv_state <= tdp_pkg::TDP_CONV_DONE;
                        // see [R13]
                        if (adc_enable[tdp_pkg::ADC_EN1_BIT]) result_one <= analog_in_one;
                        if (adc_enable[tdp_pkg::ADC_EN2_BIT]) result_two <= analog_in_two;
                    end
                end
                default: conv_state <= tdp_pkg::TDP_CONV_IDLE;
            endcase
        end
    end

    // ===========================================================
    // interrupt status: set wins over clear
    logic [IRQ_W_L-1:0] ev;
    assign ev = {conv_end, period_match};
    assign conv_done = irq_status[tdp_pkg::IRQ_CONV_BIT];
    logic [IRQ_W_L-1:0] clr;
    assign clr = w_iclr ? req.wdata[IRQ_W_L-1:0] : '0;
    // reading the vector acknowledges the period source
    logic [IRQ_W_L-1:0] vclr;
    assign vclr = r_vec ? IRQ_W_L'(1) : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status       <= '0;
            cpu_irq_line_two <= 1'b0;
        end else begin
            irq_status       <= ev | (irq_status & ~clr & ~vclr);
            cpu_irq_line_two <= |(irq_status & irq_enable);            // see [R6]
        end
    end

    // ===========================================================
    // read mux, one wait state
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0;
        case (req.addr)
            tdp_pkg::OFS_TIMER_ONE_CONTROL:      rd = {30'h0, timer_one_control};
            tdp_pkg::OFS_TIMER_ONE_PERIOD_VALUE: rd = {16'h0, timer_one_period_value};
            tdp_pkg::OFS_COMPARE_ONE_VALUE:      rd = {16'h0, compare_one_value};
            tdp_pkg::OFS_COMPARE_ONE_CONTROL:    rd = {29'h0, compare_one_control};
            tdp_pkg::OFS_CONVERTER_CONTROL_ONE:  rd = {23'h0, conv_done, 6'h0, adc_enable};
            tdp_pkg::OFS_RESULT_ONE:             rd = {22'h0, result_one};
            tdp_pkg::OFS_RESULT_TWO:             rd = {22'h0, result_two};
            tdp_pkg::OFS_IRQ_STATUS:             rd = {30'h0, irq_status};
            tdp_pkg::OFS_IRQ_ENABLE:             rd = {30'h0, irq_enable};
            tdp_pkg::OFS_GROUP_A_VECTOR:         rd = {24'h0, irq_status[0] ?
                                                       tdp_pkg::VECTOR_PERIOD : tdp_pkg::VECTOR_NONE};
            tdp_pkg::OFS_TIMER_ONE_COUNT:        rd = {16'h0, count};
            default:                             rd = 32'h0;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // answer one cycle into the access phase, registered outputs
            pready  <= req.sel && req.en && !pready;
            prdata  <= rd;
            pslverr <= req.sel && req.en && !pready && !mapped;
        end
    end

    // ===========================================================
    // checks
    property p_wrap;
        @(posedge pclk) disable iff (!presetn) running && !updown && at_period |=> count == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap"); // see [R1]
    property p_run_start;
        @(posedge pclk) disable iff (!presetn) !running && !w_tctl |=> $stable(count);
    endproperty
    a_run_start: assert property (p_run_start) else $error("timer moved while stopped"); // see [R7]
    property p_conv;
        @(posedge pclk) disable iff (!presetn)
        period_match && any_adc && conv_state != tdp_pkg::TDP_CONV_BUSY
        |=> conv_state == tdp_pkg::TDP_CONV_BUSY ##12 conv_end;
    endproperty
    a_conv: assert property (p_conv) else $error("conversion not started or wrong length"); // see [R4]
    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        (irq_status[0] && irq_enable[0]) |=> cpu_irq_line_two;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised"); // see [R6]
    property p_pin;
        @(posedge pclk) disable iff (!presetn) !pin_pwm |=> !compare_one_pwm_pin;
    endproperty
    a_pin: assert property (p_pin) else $error("pin driven in io mode"); // see [R3]
    property p_pwm_high;
        @(posedge pclk) disable iff (!presetn)
        pin_pwm && cmp_en && !compare_one_control[2] && active |=> compare_one_pwm_pin;
    endproperty
    a_pwm_high: assert property (p_pwm_high) else $error("pwm not active high"); // see [R2]
    property p_done_flag;
        @(posedge pclk) disable iff (!presetn) conv_end |=> conv_done;
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag missing"); // see [R13]
    property p_count_range;
        @(posedge pclk) disable iff (!presetn)
        running && !updown && count <= timer_one_period_value |=> count <= timer_one_period_value;
    endproperty
    a_count_range: assert property (p_count_range) else $error("count past period"); // see [R14]
    property p_oe;
        @(posedge pclk) disable iff (!presetn) pin_pwm |=> shared_digital_io_bit_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("pin not handed to pwm"); // see [R3]
    property p_turn;
        @(posedge pclk) disable iff (!presetn)
        running && updown && !down && at_period && count != '0 |=> down;
    endproperty
    a_turn: assert property (p_turn) else $error("no turn at period"); // see [R14]
    c_match: cover property (@(posedge pclk) period_match);
    c_updown: cover property (@(posedge pclk) updown && period_match);
    c_conv:  cover property (@(posedge pclk) conv_end);
    c_irq:   cover property (@(posedge pclk) $rose(cpu_irq_line_two));
endmodule
`default_nettype wire

// file: verif/tdp_analog_model.sv
// analog front end model: integrator and adder ahead of both converter inputs
// assumes pwm_in is the compare pin; the dither amplitude is one result step
`timescale 1ns/1ps
`default_nettype none
module tdp_analog_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       pwm_in,
    input  wire logic [9:0] base_one,
    input  wire logic [9:0] base_two,
    output logic      [9:0] analog_in_one,
    output logic      [9:0] analog_in_two
);
    // ===========================================================
    // adder
    // one cycle of lag stands in for the integrator, so the level follows the pin each cycle, base or base plus one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_in_one <= '0;
            analog_in_two <= '0;
        end else begin
            analog_in_one <= base_one + {9'h000, pwm_in};
            analog_in_two <= base_two + {9'h000, pwm_in};
        end
    end
endmodule
`default_nettype wire

// file: verif/triangular_dither_pwm_adc_sequencer_tb.sv
// testbench for the dithered pwm converter sequencer
// assumes tdp_pkg, the design and the analog model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module triangular_dither_pwm_adc_sequencer_tb;
    localparam logic [15:0] PER  = 16'h0028;
    localparam logic [9:0]  B1   = 10'h155;
    localparam logic [9:0]  B2   = 10'h2aa;
    logic                  pclk;
    logic                  presetn;
    tdp_pkg::tdp_apb_req_t req;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [9:0]            a_one;
    logic [9:0]            a_two;
    logic                  pwm;
    logic                  oe;
    logic                  irq;
    logic [31:0]           rd;
    logic                  err;
    int                    n_mismatch;
    int                    samples_checked;

    tdp_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(req.sel), .penable(req.en),
        .pwrite(req.wr), .paddr(req.addr), .pwdata(req.wdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .analog_in_one(a_one), .analog_in_two(a_two),
        .compare_one_pwm_pin(pwm), .shared_digital_io_bit_oe(oe), .cpu_irq_line_two(irq));
    tdp_analog_model fe_u (.pclk(pclk), .presetn(presetn), .pwm_in(pwm), .base_one(B1),
        .base_two(B2), .analog_in_one(a_one), .analog_in_two(a_two));

    // ===========================================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s: %h not %h", $time, what, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // apb transfer; ends one edge after release so the next one starts cleanly
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{sel: 1'b1, en: 1'b0, wr: w, addr: a, wdata: d};
        @(posedge pclk);
        req.en <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(0, 1, "apb timeout");
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        req <= '0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask
    // waits for the period interrupt, then takes it through the vector register
    task automatic take_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, irq}, 1, "irq seen");
        rdchk(tdp_pkg::OFS_GROUP_A_VECTOR, {24'h0, tdp_pkg::VECTOR_PERIOD}, "vector");
        if (n >= 200) begin
            give_verdict();
        end
    endtask

    // ===========================================================
    // scenarios
    task automatic t_reset();
        rdchk(tdp_pkg::OFS_TIMER_ONE_PERIOD_VALUE, {16'h0, tdp_pkg::PERIOD_RST}, "per");
        rdchk(tdp_pkg::OFS_IRQ_STATUS, 32'h0, "status");
        chk({30'h0, oe, pwm}, 32'h0, "pin idle");
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, err}, 1, "unmapped");
        chk(rd, 32'h0, "unmapped data");
    endtask
    task automatic t_init();
        apb(1'b1, tdp_pkg::OFS_TIMER_ONE_PERIOD_VALUE, {16'h0, PER});
        apb(1'b1, tdp_pkg::OFS_COMPARE_ONE_CONTROL, 32'h2);
        // the select lands at the pready edge, the registered enable follows one edge later
        @(posedge pclk);
        chk({31'h0, oe}, 1, "pin to pwm");
        apb(1'b1, tdp_pkg::OFS_COMPARE_ONE_CONTROL, 32'h3);
        apb(1'b1, tdp_pkg::OFS_CONVERTER_CONTROL_ONE, 32'h3);
        apb(1'b1, tdp_pkg::OFS_IRQ_ENABLE, 32'h1);
        rdchk(tdp_pkg::OFS_TIMER_ONE_COUNT, 32'h0, "held");
        apb(1'b1, tdp_pkg::OFS_TIMER_ONE_CONTROL, 32'h1);
        for (int i = 0; i < 12; i++) begin
            apb(1'b0, tdp_pkg::OFS_TIMER_ONE_COUNT, 32'h0);
            chk({31'h0, rd <= {16'h0, PER}}, 1, "count range");
        end
    endtask
    task automatic t_irq();
        take_irq();
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 0, "irq dropped");
        apb(1'b1, tdp_pkg::OFS_IRQ_ENABLE, 32'h0);
        repeat (PER + 4) @(posedge pclk);
        chk({31'h0, irq}, 0, "masked");
        // conversions started by each match have set the done bit as well
        rdchk(tdp_pkg::OFS_IRQ_STATUS, 32'h3, "pending");
        apb(1'b1, tdp_pkg::OFS_IRQ_ENABLE, 32'h1);
        @(posedge pclk);
        chk({31'h0, irq}, 1, "unmasked");
        apb(1'b1, tdp_pkg::OFS_IRQ_CLEAR, 32'h1);
        @(posedge pclk);
        chk({31'h0, irq}, 0, "cleared");
    endtask
    // duty and done flag for 0 percent, a middle value and 100 percent; converted level at 0 and 100 percent
    task automatic t_duty();
        logic [15:0] cv[3];
        int hi;
        cv = '{16'h0000, 16'h0010, PER + 16'h0001};
        foreach (cv[i]) begin
            apb(1'b1, tdp_pkg::OFS_COMPARE_ONE_VALUE, {16'h0, cv[i]});
            repeat (2 * (PER + 1)) @(posedge pclk);
            hi = 0;
            repeat (PER + 1) begin
                @(posedge pclk);
                hi += int'(pwm === 1'b1);
            end
            chk(hi, {16'h0, cv[i]}, "duty");
            take_irq();
            // drop the old done flag so the check below sees this conversion finish
            apb(1'b1, tdp_pkg::OFS_IRQ_CLEAR, 32'h2);
            repeat (tdp_pkg::CONV_CYCLES + 8) @(posedge pclk);
            apb(1'b0, tdp_pkg::OFS_CONVERTER_CONTROL_ONE, 32'h0);
            chk({31'h0, rd[tdp_pkg::ADC_DONE_BIT]}, 1, "done");
            if (i != 1) begin
                rdchk(tdp_pkg::OFS_RESULT_ONE, {22'h0, B1 + 10'(i / 2)}, "res1");
                rdchk(tdp_pkg::OFS_RESULT_TWO, {22'h0, B2 + 10'(i / 2)}, "res2");
            end
        end
    endtask
    // handler loop: ramp the compare value and feed results to a running sum
    task automatic t_sweep();
        logic [15:0] step;
        logic [15:0] cur;
        logic        up;
        int          acc;
        step = 16'(2 * PER / 8);
        cur = 16'h0;
        up = 1'b1;
        acc = 0;
        repeat (12) begin
            take_irq();
            if (up && cur + step > PER || !up && cur < step) begin
                up = !up;
            end
            cur = up ? cur + step : cur - step;
            apb(1'b1, tdp_pkg::OFS_COMPARE_ONE_VALUE, {16'h0, cur});
            rdchk(tdp_pkg::OFS_COMPARE_ONE_VALUE, {16'h0, cur}, "cmp");
            apb(1'b0, tdp_pkg::OFS_RESULT_ONE, 32'h0);
            chk({31'h0, rd - B1 < 2}, 1, "dither");
            acc += int'(rd);
        end
        chk({31'h0, acc >= 12 * int'(B1) && acc <= 12 * (int'(B1) + 1)}, 1, "sum");
    endtask
    // up/down counting: one period interrupt per turn, and the count falls after it
    task automatic t_updown();
        logic [31:0] first;
        apb(1'b1, tdp_pkg::OFS_TIMER_ONE_CONTROL, 32'h3);
        take_irq();
        apb(1'b0, tdp_pkg::OFS_TIMER_ONE_COUNT, 32'h0);
        chk({31'h0, rd <= {16'h0, PER}}, 1, "updown range");
        take_irq();
        apb(1'b0, tdp_pkg::OFS_TIMER_ONE_COUNT, 32'h0);
        first = rd;
        apb(1'b0, tdp_pkg::OFS_TIMER_ONE_COUNT, 32'h0);
        chk(rd, first - 32'h4, "counting down");
    endtask

    // ===========================================================
    // main sequence
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        req = '0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_init();
        t_irq();
        t_duty();
        t_sweep();
        t_updown();
        give_verdict();
    end
endmodule
`default_nettype wire
